// *** blk_card_end.sv ***
// Card end of the half-duplex block protocol: answers I-, R- and DESELECT blocks.
// Assumes the reader end speaks first and keeps its own numbering; reset is activation.
`timescale 1ns/1ps
module blk_card_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link to the reader
  blk_link_if.card link,
  // Received command bytes
  output logic rx_valid_q,
  output blk_proto_pkg::byte_t rx_data_q,
  output logic rx_end_q,
  output logic rx_abort_q,
  // Response pieces from the application
  output logic rsp_req_q,
  input wire logic tx_valid,
  input wire blk_proto_pkg::byte_t tx_data,
  input wire logic tx_last,
  input wire logic tx_more,
  output logic tx_ready,
  // Status
  output logic deselected
);
  typedef enum logic [3:0] {
    c_idle = 4'b0001,
    c_collect = 4'b0010,
    c_send = 4'b0100,
    c_halt = 4'b1000
  } card_st_e;

  blk_proto_pkg::byte_t f_pcb;
  logic f_inf_valid;
  blk_proto_pkg::byte_t f_inf_data;
  logic f_done;
  blk_proto_pkg::len_t f_len;

  frame_rx u_rx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(link.p2c_valid),
    .in_data(link.p2c_data),
    .in_last(link.p2c_last),
    .pcb_q(f_pcb),
    .inf_valid_q(f_inf_valid),
    .inf_data_q(f_inf_data),
    .done_q(f_done),
    .len_q(f_len)
  );

  card_st_e state_q, state_d;
  logic bn_q, bn_d;
  logic tx_chain_q, tx_chain_d;
  logic have_i_q, have_i_d;
  logic halt_after_q, halt_after_d;
  blk_proto_pkg::byte_t i_pcb_q, i_pcb_d;
  blk_proto_pkg::byte_t send_pcb_q, send_pcb_d;
  logic send_body_q, send_body_d;
  blk_proto_pkg::len_t ptr_q, ptr_d;
  blk_proto_pkg::len_t len_q, len_d;
  logic out_valid_q, out_valid_d;
  logic out_last_q, out_last_d;
  blk_proto_pkg::byte_t out_data_q, out_data_d;
  logic rx_valid_d, rx_end_d, rx_abort_d, rsp_req_d;
  blk_proto_pkg::byte_t rx_data_d;
  logic wr_en;
  logic piece_chain;
  blk_proto_pkg::blk_kind_e kind;

  // The last I-block stays here until a new response replaces it.
  blk_proto_pkg::byte_t mem [256];

  assign link.c2p_valid = out_valid_q;
  assign link.c2p_last = out_last_q;
  assign link.c2p_data = out_data_q;
  assign tx_ready = (state_q == c_collect);
  assign deselected = (state_q == c_halt);

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    kind = blk_proto_pkg::pcb_kind(f_pcb);
    state_d = state_q;
    bn_d = bn_q;
    tx_chain_d = tx_chain_q;
    have_i_d = have_i_q;
    halt_after_d = halt_after_q;
    i_pcb_d = i_pcb_q;
    send_pcb_d = send_pcb_q;
    send_body_d = send_body_q;
    ptr_d = ptr_q;
    len_d = len_q;
    out_valid_d = 1'b0;
    out_last_d = 1'b0;
    out_data_d = out_data_q;
    rx_end_d = 1'b0;
    rx_abort_d = 1'b0;
    rsp_req_d = 1'b0;
    wr_en = 1'b0;
    piece_chain = 1'b0;
    rx_valid_d = f_inf_valid && kind == blk_proto_pkg::blk_i && state_q == c_idle;
    rx_data_d = f_inf_data;
    unique case (state_q)
      c_idle: begin
        if (f_done) begin
          ptr_d = '0;
          unique case (kind)
            blk_proto_pkg::blk_i: begin
              if (f_len > blk_proto_pkg::inf_max) begin
                rx_abort_d = 1'b1;
              end else if (f_pcb[blk_proto_pkg::chain_bit]
                           && f_len < blk_proto_pkg::chain_min) begin
                rx_abort_d = 1'b1;
              end else begin
                bn_d = ~bn_q;
                tx_chain_d = 1'b0;
                if (f_pcb[blk_proto_pkg::chain_bit]) begin
                  // The ACK carries the number just received.
                  send_pcb_d = blk_proto_pkg::mk_pcb(blk_proto_pkg::pcb_r, 1'b0, ~bn_q);
                  send_body_d = 1'b0;
                  state_d = c_send;
                end else begin
                  rx_end_d = 1'b1;
                  rsp_req_d = 1'b1;
                  len_d = '0;
                  state_d = c_collect;
                end
              end
            end
            blk_proto_pkg::blk_r: begin
              if (f_len == '0) begin
                if (f_pcb[blk_proto_pkg::bn_bit] == bn_q) begin
                  if (have_i_q) begin
                    send_pcb_d = i_pcb_q;
                    send_body_d = 1'b1;
                    state_d = c_send;
                  end
                end else if (f_pcb[blk_proto_pkg::nak_bit]) begin
                  // A NAK leaves the number alone.
                  send_pcb_d = blk_proto_pkg::mk_pcb(blk_proto_pkg::pcb_r, 1'b0, bn_q);
                  send_body_d = 1'b0;
                  state_d = c_send;
                end else if (tx_chain_q) begin
                  bn_d = ~bn_q;
                  rsp_req_d = 1'b1;
                  len_d = '0;
                  state_d = c_collect;
                end
              end
            end
            blk_proto_pkg::blk_s: begin
              if (f_len == '0) begin
                send_pcb_d = blk_proto_pkg::pcb_desel;
                send_body_d = 1'b0;
                halt_after_d = 1'b1;
                state_d = c_send;
              end
            end
            blk_proto_pkg::blk_bad: begin
            end
          endcase
        end
      end
      c_collect: begin
        if (tx_valid) begin
          // Bytes past the field limit are dropped rather than overrun the frame.
          if (len_q < blk_proto_pkg::inf_max) begin
            wr_en = 1'b1;
            len_d = len_q + 9'h001;
          end
          if (tx_last) begin
            piece_chain = tx_more && len_d >= blk_proto_pkg::chain_min;
            i_pcb_d = blk_proto_pkg::mk_pcb(blk_proto_pkg::pcb_i, piece_chain, bn_q);
            send_pcb_d = i_pcb_d;
            tx_chain_d = piece_chain;
            have_i_d = 1'b1;
            send_body_d = 1'b1;
            ptr_d = '0;
            state_d = c_send;
          end
        end
      end
      c_send: begin
        // Only I, R and DESELECT codes ever reach the link.
        out_valid_d = 1'b1;
        out_data_d = (ptr_q == '0) ? send_pcb_q : mem[8'(ptr_q - 9'h001)];
        out_last_d = !send_body_q || ptr_q == len_q;
        ptr_d = ptr_q + 9'h001;
        if (out_last_d) begin
          state_d = halt_after_q ? c_halt : c_idle;
        end
      end
      c_halt: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= c_idle;
      bn_q <= blk_proto_pkg::card_bn_init;
      tx_chain_q <= 1'b0;
      have_i_q <= 1'b0;
      halt_after_q <= 1'b0;
      i_pcb_q <= '0;
      send_pcb_q <= '0;
      send_body_q <= 1'b0;
      ptr_q <= '0;
      len_q <= '0;
      out_valid_q <= 1'b0;
      out_last_q <= 1'b0;
      out_data_q <= '0;
      rx_valid_q <= 1'b0;
      rx_data_q <= '0;
      rx_end_q <= 1'b0;
      rx_abort_q <= 1'b0;
      rsp_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bn_q <= bn_d;
      tx_chain_q <= tx_chain_d;
      have_i_q <= have_i_d;
      halt_after_q <= halt_after_d;
      i_pcb_q <= i_pcb_d;
      send_pcb_q <= send_pcb_d;
      send_body_q <= send_body_d;
      ptr_q <= ptr_d;
      len_q <= len_d;
      out_valid_q <= out_valid_d;
      out_last_q <= out_last_d;
      out_data_q <= out_data_d;
      rx_valid_q <= rx_valid_d;
      rx_data_q <= rx_data_d;
      rx_end_q <= rx_end_d;
      rx_abort_q <= rx_abort_d;
      rsp_req_q <= rsp_req_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[len_q[7:0]] <= tx_data;
    end
  end
endmodule

// *** blk_link_asserts.sv ***
// Checker for the byte link that joins the reader end and the card end.
// Assumes it sits beside the interface on clk_sys and sees its signals directly.
`timescale 1ns/1ps
module blk_link_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Reader to card
  input wire logic p2c_valid,
  input wire logic p2c_last,
  input wire blk_proto_pkg::byte_t p2c_data,
  // Card to reader
  input wire logic c2p_valid,
  input wire logic c2p_last,
  input wire blk_proto_pkg::byte_t c2p_data
);
  logic p_first_q, p_first_d, c_first_q, c_first_d, chain_q, chain_d;
  logic bn_q, bn_d, spoke_q, spoke_d;
  blk_proto_pkg::len_t cnt_q, cnt_d;
  wire logic p_pcb = p2c_valid && p_first_q;
  wire logic c_pcb = c2p_valid && c_first_q;
  wire logic p_end = p2c_valid && p2c_last;
  wire logic c_end = c2p_valid && c2p_last;

  //////////////////////////////////////////////////////////////////////////////
  // The number of the last reader block is kept so that card replies can be tied to it.
  always_comb begin
    p_first_d = p2c_valid ? p2c_last : p_first_q;
    c_first_d = c2p_valid ? c2p_last : c_first_q;
    chain_d = p_pcb ? (p2c_data[7:5] == 3'h0 && p2c_data[4]) : chain_q;
    bn_d = (p_pcb && p2c_data[7:6] != 2'h3) ? p2c_data[0] : bn_q;
    spoke_d = spoke_q || p2c_valid;
    cnt_d = (p_end || c_end) ? 9'h000 : cnt_q + 9'(p2c_valid || c2p_valid);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {p_first_q, c_first_q, chain_q, bn_q, spoke_q, cnt_q} <= {5'h18, 9'h000};
    end else begin
      {p_first_q, c_first_q, chain_q, bn_q, spoke_q, cnt_q} <=
        {p_first_d, c_first_d, chain_d, bn_d, spoke_d, cnt_d};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_desel_rsp;
    c2p_valid && c2p_last && c2p_data == blk_proto_pkg::pcb_desel;
  endsequence
  sequence s_chain_ack;
    c2p_valid && c2p_last && c2p_data == (blk_proto_pkg::pcb_r | {7'h00, bn_q});
  endsequence

  // A reply byte is sampled three edges after the last byte of the request.
  chk_desel_answered: assert property (p_pcb && p2c_last && p2c_data == 8'hC2
      |-> ##3 s_desel_rsp)
    else $error("DESELECT not answered");
  chk_chain_acked: assert property (p_end && !p_first_q && chain_q |-> ##3 s_chain_ack)
    else $error("chained block not acknowledged");
  chk_no_wtx: assert property (c_pcb && c2p_data[7:6] == 2'h3 |-> c2p_data == 8'hC2)
    else $error("card sent an S-block other than DESELECT");
  chk_r_no_inf: assert property (c_pcb && c2p_data[7:5] == 3'h5 |-> c2p_last)
    else $error("R-block carries bytes");
  // The idle side still shows its last byte, so only the side sending a PCB is looked at.
  chk_no_cid_nad: assert property (p_pcb || c_pcb
      |-> (p_pcb ? p2c_data[3:2] : c2p_data[3:2]) == 2'h0)
    else $error("block carries CID or NAD");
  chk_reader_first: assert property (c2p_valid |-> spoke_q)
    else $error("card spoke first");
  chk_half_duplex: assert property (!(p2c_valid && c2p_valid))
    else $error("both ends sending");
  chk_frame_size: assert property (p2c_valid || c2p_valid |-> cnt_q < 9'h0FE)
    else $error("frame longer than the data field");
  chk_reply_bn: assert property (c_pcb && c2p_data[7:5] == 3'h0
      |-> c2p_data[0] == bn_q)
    else $error("card I-block number wrong");
endmodule

// *** blk_link_if.sv ***
// Byte link between the reader end and the card end.
// Both ends share clk_sys; each frame is a burst of valid bytes closed by last.
`timescale 1ns/1ps
interface blk_link_if (
  input wire logic clk_sys
);
  logic p2c_valid;
  logic p2c_last;
  blk_proto_pkg::byte_t p2c_data;
  logic c2p_valid;
  logic c2p_last;
  blk_proto_pkg::byte_t c2p_data;

  modport card (
    input p2c_valid,
    input p2c_last,
    input p2c_data,
    output c2p_valid,
    output c2p_last,
    output c2p_data
  );

  modport reader (
    output p2c_valid,
    output p2c_last,
    output p2c_data,
    input c2p_valid,
    input c2p_last,
    input c2p_data
  );
endinterface

// *** blk_proto_pkg.sv ***
// Shared constants, block codings and decode helpers for the block protocol.
// Assumes both ends run on one clk_sys and see each frame as PCB plus INF bytes;
// CRC and SOF/EOF framing live below this layer.
package blk_proto_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [8:0] len_t;

  // Clock, frame waiting time and DESELECT retries, in their own units.
  localparam int clk_period_ns = 50;
  localparam int fwt_ns = 302_000;
  localparam int fwt_cycles = (fwt_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [1:0] desel_retries = 2'h2;

  // Frame sizes in bytes; the data field also carries the PCB and two CRC bytes.
  localparam len_t field_max = 9'h100;
  localparam len_t crc_bytes = 9'h002;
  localparam len_t inf_max = field_max - crc_bytes - 9'h001;
  localparam len_t chain_min = 9'h040;

  // PCB codings and field positions.
  localparam byte_t pcb_i = 8'h02;
  localparam byte_t pcb_r = 8'hA2;
  localparam byte_t pcb_desel = 8'hC2;
  localparam int bn_bit = 0;
  localparam int chain_bit = 4;
  localparam int nak_bit = 4;

  // Block numbers at activation.
  localparam logic card_bn_init = 1'b1;
  localparam logic reader_bn_init = 1'b0;

  typedef enum logic [3:0] {
    blk_i = 4'b0001,
    blk_r = 4'b0010,
    blk_s = 4'b0100,
    blk_bad = 4'b1000
  } blk_kind_e;

  // A set CID or NAD bit makes the block illegal, as does any S-block but DESELECT.
  function automatic blk_kind_e pcb_kind(input byte_t p);
    blk_kind_e k;
    k = blk_bad;
    if (p[7:5] == 3'h0 && p[3:1] == 3'h1) begin
      k = blk_i;
    end else if (p[7:5] == 3'h5 && p[3:1] == 3'h1) begin
      k = blk_r;
    end else if (p == pcb_desel) begin
      k = blk_s;
    end
    return k;
  endfunction

  function automatic byte_t mk_pcb(input byte_t base, input logic flag, input logic bn);
    byte_t v;
    v = base;
    v[chain_bit] = flag;
    v[bn_bit] = bn;
    return v;
  endfunction

endpackage

// *** blk_reader_end.sv ***
// Reader end of the block protocol: sends commands, keeps numbering, recovers errors.
// Assumes one card on the link that answers within the frame waiting time.
`timescale 1ns/1ps
module blk_reader_end #(
  parameter int FWT_CYCLES = blk_proto_pkg::fwt_cycles
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link to the card
  blk_link_if.reader link,
  // Command pieces
  input wire logic cmd_valid,
  input wire blk_proto_pkg::byte_t cmd_data,
  input wire logic cmd_last,
  input wire logic cmd_more,
  output logic cmd_ready,
  output logic next_req_q,
  input wire logic desel_req,
  // Response bytes
  output logic rsp_valid_q,
  output blk_proto_pkg::byte_t rsp_data_q,
  output logic rsp_end_q,
  // Status
  output logic deselected,
  output logic give_up_q
);
  typedef enum logic [4:0] {
    r_idle = 5'b00001,
    r_load = 5'b00010,
    r_send = 5'b00100,
    r_wait = 5'b01000,
    r_off = 5'b10000
  } rd_st_e;

  blk_proto_pkg::byte_t f_pcb;
  logic f_inf_valid;
  blk_proto_pkg::byte_t f_inf_data;
  logic f_done;
  blk_proto_pkg::len_t f_len;

  frame_rx u_rx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(link.c2p_valid),
    .in_data(link.c2p_data),
    .in_last(link.c2p_last),
    .pcb_q(f_pcb),
    .inf_valid_q(f_inf_valid),
    .inf_data_q(f_inf_data),
    .done_q(f_done),
    .len_q(f_len)
  );

  rd_st_e state_q, state_d;
  logic bn_q, bn_d, tx_chain_q, tx_chain_d, rx_chain_q, rx_chain_d;
  logic desel_q, desel_d, send_body_q, send_body_d, give_up_d;
  logic [1:0] retry_q, retry_d;
  blk_proto_pkg::byte_t i_pcb_q, i_pcb_d, send_pcb_q, send_pcb_d;
  blk_proto_pkg::len_t ptr_q, ptr_d, len_q, len_d;
  logic [23:0] timer_q, timer_d;
  logic out_valid_q, out_valid_d, out_last_q, out_last_d;
  blk_proto_pkg::byte_t out_data_q, out_data_d;
  logic next_req_d, rsp_valid_d, rsp_end_d, wr_en, err, piece_chain;
  blk_proto_pkg::blk_kind_e kind;
  blk_proto_pkg::byte_t mem [256];

  assign link.p2c_valid = out_valid_q;
  assign link.p2c_last = out_last_q;
  assign link.p2c_data = out_data_q;
  assign cmd_ready = (state_q == r_idle && !desel_req) || state_q == r_load;
  assign deselected = (state_q == r_off);

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    kind = blk_proto_pkg::pcb_kind(f_pcb);
    state_d = state_q;
    {bn_d, tx_chain_d, rx_chain_d} = {bn_q, tx_chain_q, rx_chain_q};
    {desel_d, send_body_d, give_up_d, retry_d} = {desel_q, send_body_q, give_up_q, retry_q};
    {i_pcb_d, send_pcb_d, ptr_d, len_d} = {i_pcb_q, send_pcb_q, ptr_q, len_q};
    timer_d = timer_q + 24'h00_0001;
    out_valid_d = 1'b0;
    out_last_d = 1'b0;
    out_data_d = out_data_q;
    next_req_d = 1'b0;
    rsp_end_d = 1'b0;
    wr_en = 1'b0;
    err = 1'b0;
    piece_chain = 1'b0;
    rsp_valid_d = f_inf_valid && kind == blk_proto_pkg::blk_i && state_q == r_wait;
    unique case (state_q)
      r_idle, r_load: begin
        if (state_q == r_idle && desel_req) begin
          desel_d = 1'b1;
          retry_d = '0;
          send_pcb_d = blk_proto_pkg::pcb_desel;
          send_body_d = 1'b0;
          state_d = r_send;
        end else if (cmd_valid) begin
          state_d = r_load;
          if (len_q < blk_proto_pkg::inf_max) begin
            wr_en = 1'b1;
            len_d = len_q + 9'h001;
          end
          if (cmd_last) begin
            piece_chain = cmd_more && len_d >= blk_proto_pkg::chain_min;
            i_pcb_d = blk_proto_pkg::mk_pcb(blk_proto_pkg::pcb_i, piece_chain, bn_q);
            send_pcb_d = i_pcb_d;
            tx_chain_d = piece_chain;
            send_body_d = 1'b1;
            state_d = r_send;
          end
        end
      end
      r_send: begin
        out_valid_d = 1'b1;
        out_data_d = (ptr_q == '0) ? send_pcb_q : mem[8'(ptr_q - 9'h001)];
        out_last_d = !send_body_q || ptr_q == len_q;
        ptr_d = ptr_q + 9'h001;
        if (out_last_d) begin
          timer_d = '0;
          state_d = r_wait;
        end
      end
      r_wait: begin
        if (f_done) begin
          if (desel_q) begin
            err = !(kind == blk_proto_pkg::blk_s && f_len == '0);
            if (!err) begin
              state_d = r_off;
            end
          end else if (kind == blk_proto_pkg::blk_i && f_pcb[blk_proto_pkg::bn_bit] == bn_q) begin
            bn_d = ~bn_q;
            tx_chain_d = 1'b0;
            rx_chain_d = f_pcb[blk_proto_pkg::chain_bit];
            if (f_pcb[blk_proto_pkg::chain_bit]) begin
              send_pcb_d = blk_proto_pkg::mk_pcb(blk_proto_pkg::pcb_r, 1'b0, ~bn_q);
              send_body_d = 1'b0;
              state_d = r_send;
            end else begin
              rsp_end_d = 1'b1;
              len_d = '0;
              state_d = r_idle;
            end
          end else if (kind == blk_proto_pkg::blk_r && !f_pcb[blk_proto_pkg::nak_bit]
                       && f_len == '0 && tx_chain_q) begin
            if (f_pcb[blk_proto_pkg::bn_bit] == bn_q) begin
              bn_d = ~bn_q;
              next_req_d = 1'b1;
              len_d = '0;
              state_d = r_load;
            end else begin
              send_pcb_d = i_pcb_q;
              send_body_d = 1'b1;
              state_d = r_send;
            end
          end else begin
            err = 1'b1;
          end
        end else if (timer_q >= 24'(FWT_CYCLES - 1)) begin
          err = 1'b1;
        end
        if (err) begin
          send_body_d = 1'b0;
          state_d = r_send;
          if (desel_q) begin
            send_pcb_d = blk_proto_pkg::pcb_desel;
            retry_d = retry_q + 2'h1;
            if (retry_q == blk_proto_pkg::desel_retries) begin
              give_up_d = 1'b1;
              state_d = r_off;
            end
          end else begin
            // While the card chains, an ACK asks it to go on.
            send_pcb_d = blk_proto_pkg::mk_pcb(blk_proto_pkg::pcb_r, !rx_chain_q, bn_q);
          end
        end
      end
      r_off: begin
      end
    endcase
    if (state_d == r_send && state_q != r_send) begin
      ptr_d = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= r_idle;
      bn_q <= blk_proto_pkg::reader_bn_init;
      {tx_chain_q, rx_chain_q, desel_q, send_body_q, give_up_q} <= '0;
      {retry_q, i_pcb_q, send_pcb_q, ptr_q, len_q, timer_q} <= '0;
      {out_valid_q, out_last_q, out_data_q} <= '0;
      {next_req_q, rsp_valid_q, rsp_data_q, rsp_end_q} <= '0;
    end else begin
      state_q <= state_d;
      {bn_q, tx_chain_q, rx_chain_q} <= {bn_d, tx_chain_d, rx_chain_d};
      {desel_q, send_body_q, give_up_q, retry_q} <= {desel_d, send_body_d, give_up_d, retry_d};
      {i_pcb_q, send_pcb_q, ptr_q, len_q, timer_q} <= {i_pcb_d, send_pcb_d, ptr_d, len_d, timer_d};
      {out_valid_q, out_last_q, out_data_q} <= {out_valid_d, out_last_d, out_data_d};
      {next_req_q, rsp_valid_q, rsp_data_q, rsp_end_q} <= {next_req_d, rsp_valid_d, f_inf_data,
                                                          rsp_end_d};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[len_q[7:0]] <= cmd_data;
    end
  end
endmodule

// *** contactless_block_protocol_ctrl_tb.sv ***
// Testbench: reader end and card end on one link, a second card end driven directly.
// Assumes the package, interface, design and checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); fail_count++; end end
`define WAITC(c) begin for (int k = 0; k < 400 && !(c); k++) @(posedge clk_sys); \
  `CHK(c, 1'b1) end
module contactless_block_protocol_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0, tx_valid = 1'b0, lst = 1'b0, mor = 1'b0, desel_req = 1'b0;
  blk_proto_pkg::byte_t dat = 8'h00, rx_data, rsp_data, last_rx, last_rsp;
  logic cmd_ready, next_req, rx_valid, rx_end, rx_abort, rsp_valid, rsp_end;
  logic tx_ready_a, tx_ready_b, card_desel, rd_desel, give_up;
  int fail_count = 0, samples_checked = 0;
  int n_rx = 0, n_end = 0, n_rsp = 0, n_rend = 0, n_next = 0, n_abort = 0, n_bfr = 0;
  blk_proto_pkg::byte_t bq[$];
  blk_proto_pkg::byte_t rpcb[3] = '{8'hB3, 8'hA2, 8'hB2};
  blk_proto_pkg::byte_t rexp[3] = '{8'hA2, 8'h02, 8'h02};
  int rlen[3] = '{1, 2, 2};

  blk_link_if blk_link_if_i (.clk_sys(clk_sys));
  blk_link_if blk_link_if_b (.clk_sys(clk_sys));
  // The wait must cover a 64-byte answer from the card application plus its transmission.
  blk_reader_end #(.FWT_CYCLES(200)) blk_reader_end_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(blk_link_if_i), .cmd_valid(cmd_valid), .cmd_data(dat), .cmd_last(lst),
    .cmd_more(mor), .cmd_ready(cmd_ready), .next_req_q(next_req), .desel_req(desel_req),
    .rsp_valid_q(rsp_valid), .rsp_data_q(rsp_data), .rsp_end_q(rsp_end),
    .deselected(rd_desel), .give_up_q(give_up));
  blk_card_end blk_card_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(blk_link_if_i),
    .rx_valid_q(rx_valid), .rx_data_q(rx_data), .rx_end_q(rx_end), .rx_abort_q(),
    .rsp_req_q(), .tx_valid(tx_valid), .tx_data(dat), .tx_last(lst), .tx_more(mor),
    .tx_ready(tx_ready_a), .deselected(card_desel));
  blk_card_end blk_card_end_b (.clk_sys(clk_sys), .rst_n(rst_n), .link(blk_link_if_b),
    .rx_valid_q(), .rx_data_q(), .rx_end_q(), .rx_abort_q(rx_abort), .rsp_req_q(),
    .tx_valid(tx_valid), .tx_data(dat), .tx_last(lst), .tx_more(mor),
    .tx_ready(tx_ready_b), .deselected());
  blk_link_asserts blk_link_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .p2c_valid(blk_link_if_i.p2c_valid), .p2c_last(blk_link_if_i.p2c_last),
    .p2c_data(blk_link_if_i.p2c_data), .c2p_valid(blk_link_if_i.c2p_valid),
    .c2p_last(blk_link_if_i.c2p_last), .c2p_data(blk_link_if_i.c2p_data));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    n_rx += int'(rx_valid);
    n_end += int'(rx_end);
    n_rsp += int'(rsp_valid);
    n_rend += int'(rsp_end);
    n_next += int'(next_req);
    n_abort += int'(rx_abort);
    n_bfr += int'(blk_link_if_b.c2p_valid && blk_link_if_b.c2p_last);
    if (rx_valid) last_rx = rx_data;
    if (rsp_valid) last_rsp = rsp_data;
    if (blk_link_if_b.c2p_valid) bq.push_back(blk_link_if_b.c2p_data);
  end

  // One piece of n bytes, to the reader end or to whichever card end collects.
  task automatic put(input bit cmd, input int n, input bit more);
    for (int i = 0; i < n; i++) begin
      cmd_valid <= cmd;
      tx_valid <= !cmd;
      dat <= 8'(i);
      lst <= (i == n - 1);
      mor <= more;
      @(posedge clk_sys);
      `WAITC(cmd ? cmd_ready : (tx_ready_a | tx_ready_b))
    end
    cmd_valid <= 1'b0;
    tx_valid <= 1'b0;
    dat <= ~dat;
    @(posedge clk_sys);
  endtask

  // A frame of PCB and n bytes to the directly driven card; replies land in bq.
  task automatic sendb(input blk_proto_pkg::byte_t pcb, input int n);
    bq.delete();
    for (int i = 0; i <= n; i++) begin
      blk_link_if_b.p2c_valid <= 1'b1;
      blk_link_if_b.p2c_data <= (i == 0) ? pcb : 8'(i);
      blk_link_if_b.p2c_last <= (i == n);
      @(posedge clk_sys);
    end
    blk_link_if_b.p2c_valid <= 1'b0;
    blk_link_if_b.p2c_data <= ~blk_link_if_b.p2c_data;
    repeat (30) @(posedge clk_sys);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    blk_link_if_b.p2c_valid <= 1'b0;
    blk_link_if_b.p2c_last <= 1'b0;
    blk_link_if_b.p2c_data <= 8'h00;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    put(1, 3, 0);
    `WAITC(n_end == 1)
    `CHK(n_rx, 3)
    `CHK(last_rx, 8'h02)
    put(0, 2, 0);
    `WAITC(n_rend == 1)
    `CHK(n_rsp, 2)
    put(1, 64, 1);
    `WAITC(n_next == 1)
    `CHK(n_next, 1)
    put(1, 2, 0);
    `WAITC(n_end == 2)
    `CHK(n_rx, 69)
    put(0, 1, 0);
    `WAITC(n_rend == 2)
    put(1, 1, 0);
    `WAITC(n_end == 3)
    put(0, 64, 1);
    put(0, 2, 0);
    `WAITC(n_rend == 3)
    `CHK(n_rsp, 69)
    `CHK(last_rsp, 8'h01)
    sendb(8'h02, 1);
    put(0, 1, 0);
    `WAITC(n_bfr == 1)
    `CHK(bq[0], 8'h02)
    // Foreign NAK, then matching ACK and NAK that must bring back the stored I-block.
    for (int t = 0; t < 3; t++) begin
      sendb(rpcb[t], 0);
      `CHK(bq.size(), rlen[t])
      `CHK(bq[0], rexp[t])
    end
    sendb(8'h0A, 1);
    `CHK(bq.size(), 0)
    sendb(8'h13, 3);
    `CHK(bq.size(), 0)
    `CHK(n_abort, 1)
    desel_req <= 1'b1;
    @(posedge clk_sys);
    desel_req <= 1'b0;
    `WAITC(rd_desel === 1'b1)
    `CHK(card_desel, 1'b1)
    `CHK(rd_desel, 1'b1)
    `CHK(give_up, 1'b0)
    end_of_test();
  end
endmodule

// *** frame_rx.sv ***
// Splits an incoming frame into its PCB and INF bytes and counts the INF bytes.
// Assumes the source runs on clk_sys and never sends a byte it cannot finish.
`timescale 1ns/1ps
module frame_rx (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Incoming bytes
  input wire logic in_valid,
  input wire blk_proto_pkg::byte_t in_data,
  input wire logic in_last,
  // Decoded frame
  output blk_proto_pkg::byte_t pcb_q,
  output logic inf_valid_q,
  output blk_proto_pkg::byte_t inf_data_q,
  output logic done_q,
  output blk_proto_pkg::len_t len_q
);
  logic first_q;
  logic first_d;
  blk_proto_pkg::byte_t pcb_d;
  logic inf_valid_d;
  blk_proto_pkg::byte_t inf_data_d;
  logic done_d;
  blk_proto_pkg::len_t len_d;

  always_comb begin
    first_d = first_q;
    pcb_d = pcb_q;
    inf_valid_d = 1'b0;
    inf_data_d = inf_data_q;
    done_d = 1'b0;
    len_d = len_q;
    if (in_valid) begin
      if (first_q) begin
        pcb_d = in_data;
        len_d = '0;
      end else begin
        inf_valid_d = 1'b1;
        inf_data_d = in_data;
        // Saturate so an oversize frame can never look short again.
        if (len_q != '1) begin
          len_d = len_q + 9'h001;
        end
      end
      first_d = in_last;
      done_d = in_last;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      first_q <= 1'b1;
      pcb_q <= '0;
      inf_valid_q <= 1'b0;
      inf_data_q <= '0;
      done_q <= 1'b0;
      len_q <= '0;
    end else begin
      first_q <= first_d;
      pcb_q <= pcb_d;
      inf_valid_q <= inf_valid_d;
      inf_data_q <= inf_data_d;
      done_q <= done_d;
      len_q <= len_d;
    end
  end
endmodule
